// File: rtl/core_subset_pkg.sv
// Constants, field layouts and types for the byte and literal core subset.
// Assumes a single 50 MHz clock and a plain register port of its own.
package core_subset_pkg;

  // Widths of the instruction word, operands, program counter and register port.
  localparam int INSN_W  = 14;
  localparam int FADDR_W = 7;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 13;
  localparam int PCL_W   = 11;
  localparam int PLH_W   = 5;
  localparam int RADDR_W = 8;
  localparam int RDATA_W = 32;

  // Field positions inside the instruction word and the counter high latch.
  localparam int DEST_BIT = 7;
  localparam int PLH_HI   = 4;
  localparam int PLH_LO   = 3;

  // Opcode patterns, matched against the top bits of the word.
  localparam logic [2:0] OP_BRANCH    = 3'h5;
  localparam logic [5:0] OP_INC_FILE  = 6'h0A;
  localparam logic [5:0] OP_INC_SKIP  = 6'h0F;
  localparam logic [5:0] OP_OR_FILE   = 6'h04;
  localparam logic [5:0] OP_MOVE_FILE = 6'h08;
  localparam logic [5:0] OP_STORE_W   = 6'h00;
  localparam logic [5:0] OP_OR_LIT    = 6'h38;
  localparam logic [3:0] OP_LOAD_LIT  = 4'hC;

  // Register port offsets and bit positions.
  localparam logic [RADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [RADDR_W-1:0] REG_PCHIGH = 8'h04;
  localparam logic [RADDR_W-1:0] REG_WORK   = 8'h08;
  localparam logic [RADDR_W-1:0] REG_STATUS = 8'h0C;
  localparam logic [RADDR_W-1:0] REG_PC     = 8'h10;
  localparam int CTRL_RUN_BIT  = 0;
  localparam int STAT_ZERO_BIT = 0;
  localparam int STAT_NOP_BIT  = 1;

  // Reset values, and the constants one and zero.
  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
  localparam logic [PLH_W-1:0]  PLH_RST  = 5'h00;
  localparam logic [DATA_W-1:0] ONE      = 8'h01;
  localparam logic [DATA_W-1:0] ZERO     = 8'h00;

  // The four oscillator periods of one instruction cycle.
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_t;

endpackage : core_subset_pkg

// File: rtl/core_subset.sv
// Decode and execute logic for a byte and literal instruction subset.
// Assumes program memory and file space answer combinationally to the
// address outputs, and that all inputs are synchronous to clock.
// Operation
// - Each instruction takes one cycle, and a taken skip or a branch adds a second cycle that does nothing.
// - An instruction cycle is four clocks: decode, read, process and write.
// - Byte operations send the result to the working register when the destination bit is zero and to the file register when it is one.
// - A branch loads the eleven-bit literal into the low counter bits and bits 4:3 of the high latch into the top two, in two cycles.
// - Increment-and-skip adds one into the destination, leaves the flags alone and voids the next instruction when the result is zero.
// - Or-literal ORs the working register with the literal into the working register and updates the zero flag.
// - Or-file ORs the working register with the file register into the chosen destination and updates the zero flag.
// - Load-literal puts the literal in the working register and touches no flag, ignoring the two don't-care bits.
// - Move-file copies the register to the chosen destination and updates the zero flag, so a write-back is a zero test.
// - Instruction words are fourteen bits, an opcode field plus operand fields.
// - The file operand is a seven-bit address from 0x00 to 0x7F.
//
// Design decisions made here: strobed register access and the address map.

`timescale 1ns/1ps

module core_subset
  import core_subset_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic [RADDR_W-1:0] reg_addr,
  input  wire logic [RDATA_W-1:0] reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [RDATA_W-1:0] reg_rdata,
  output logic      [PC_W-1:0]    prog_addr,
  input  wire logic [INSN_W-1:0]  prog_data,
  output logic      [FADDR_W-1:0] file_addr,
  input  wire logic [DATA_W-1:0]  file_rdata,
  output logic      [DATA_W-1:0]  file_wdata,
  output logic                    file_we,
  output logic      [1:0]         phase
);

  phase_t              phase_ff;
  phase_t              nxt_phase;
  logic [INSN_W-1:0]   insn_ff;
  logic [DATA_W-1:0]   opnd_ff;
  logic [DATA_W-1:0]   result_ff;
  logic [DATA_W-1:0]   work_ff;
  logic                zero_ff;
  logic                void_ff;
  logic [PC_W-1:0]     pc_ff;
  logic [PLH_W-1:0]    plh_ff;
  logic                run_ff;
  logic [FADDR_W-1:0]  file_addr_ff;
  logic [DATA_W-1:0]   file_wdata_ff;
  logic                file_we_ff;
  logic [RDATA_W-1:0]  rdata_ff;

  // Opcode decode; a voided cycle decodes as nothing at all.
  wire live        = ~void_ff;
  wire is_branch   = live && (insn_ff[13:11] == OP_BRANCH);
  wire is_inc_file = live && (insn_ff[13:8] == OP_INC_FILE);
  wire is_inc_skip = live && (insn_ff[13:8] == OP_INC_SKIP);
  wire is_or_file  = live && (insn_ff[13:8] == OP_OR_FILE);
  wire is_move     = live && (insn_ff[13:8] == OP_MOVE_FILE);
  wire is_store_w  = live && (insn_ff[13:8] == OP_STORE_W)
                          && insn_ff[DEST_BIT];
  wire is_or_lit   = live && (insn_ff[13:8] == OP_OR_LIT);
  wire is_load_lit = live && (insn_ff[13:10] == OP_LOAD_LIT);
  wire is_byte_op  = is_inc_file | is_inc_skip | is_or_file | is_move;
  wire dest_file   = insn_ff[DEST_BIT];
  wire [DATA_W-1:0] literal = insn_ff[DATA_W-1:0];

  // Result selection for the process phase.
  wire [DATA_W-1:0] inc_val = opnd_ff + ONE;
  wire [DATA_W-1:0] nxt_result =
      (is_inc_file | is_inc_skip) ? inc_val :
      is_or_file  ? (work_ff | opnd_ff) :
      is_move     ? opnd_ff :
      is_store_w  ? work_ff :
      is_or_lit   ? (work_ff | literal) :
      is_load_lit ? literal : ZERO;

  // Destination and flag steering for the write phase.
  wire to_file  = (is_byte_op && dest_file) || is_store_w;
  wire to_work  = (is_byte_op && !dest_file) || is_or_lit || is_load_lit;
  wire zero_upd = is_inc_file | is_or_file | is_move | is_or_lit;
  wire res_zero = (result_ff == ZERO);
  wire skip     = is_inc_skip && res_zero;

  // A taken skip or branch makes the following cycle a no-operation.
  wire nxt_void = is_branch | skip;
  wire [PC_W-1:0] pc_branch =
      {plh_ff[PLH_HI:PLH_LO], insn_ff[PCL_W-1:0]};
  // The branch lands one short of its target. The voided second cycle
  // still steps the counter, so the counter reaches the target and the
  // target word runs next, without a second register to tell skips from
  // branches. Software that reads the counter during that voided cycle
  // sees the target minus one.
  wire [PC_W-1:0] pc_land = pc_branch - PC_W'(1);
  wire [PC_W-1:0] pc_step = pc_ff + PC_W'(1);
  wire [PC_W-1:0] nxt_pc  = is_branch ? pc_land : pc_step;

  // The cycle only starts while running, but a started cycle finishes.
  always_comb
  begin
    nxt_phase = phase_ff;
    case (phase_ff)
      PH_DECODE:  nxt_phase = run_ff ? PH_READ : PH_DECODE;
      PH_READ:    nxt_phase = PH_PROCESS;
      PH_PROCESS: nxt_phase = PH_WRITE;
      PH_WRITE:   nxt_phase = PH_DECODE;
      default:    nxt_phase = PH_DECODE;
    endcase
  end

  // Register port decode.
  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  wire wr_plh  = reg_wr && (reg_addr == REG_PCHIGH);
  wire [RDATA_W-1:0] rd_mux =
      (reg_addr == REG_CTRL)   ? RDATA_W'(run_ff) :
      (reg_addr == REG_PCHIGH) ? RDATA_W'(plh_ff) :
      (reg_addr == REG_WORK)   ? RDATA_W'(work_ff) :
      (reg_addr == REG_STATUS) ? RDATA_W'({void_ff, zero_ff}) :
      (reg_addr == REG_PC)     ? RDATA_W'(pc_ff) : '0;
  wire [RDATA_W-1:0] nxt_rdata = reg_rd ? rd_mux : '0;

  // Phase sequencer.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      phase_ff <= PH_DECODE;
    else
      phase_ff <= nxt_phase;
  end

  // Decode phase: latch the word and present its file address.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      insn_ff      <= '0;
      file_addr_ff <= '0;
    end
    else if (phase_ff == PH_DECODE && run_ff)
    begin
      insn_ff      <= prog_data;
      file_addr_ff <= prog_data[FADDR_W-1:0];
    end
  end

  // Read and process phases: fetch the operand, then form the result.
  // The write strobe is armed here so it is high for the whole write clock.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opnd_ff       <= ZERO;
      result_ff     <= ZERO;
      file_wdata_ff <= ZERO;
      file_we_ff    <= 1'b0;
    end
    else
    begin
      if (phase_ff == PH_READ)
        opnd_ff <= file_rdata;
      if (phase_ff == PH_PROCESS)
      begin
        result_ff     <= nxt_result;
        file_wdata_ff <= nxt_result;
      end
      file_we_ff <= (phase_ff == PH_PROCESS) && to_file;
    end
  end

  // Write phase: working register, zero flag and program counter.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      work_ff <= WORK_RST;
      zero_ff <= 1'b0;
      pc_ff   <= PC_RST;
      void_ff <= 1'b0;
    end
    else if (phase_ff == PH_WRITE)
    begin
      if (to_work)
        work_ff <= result_ff;
      if (zero_upd)
        zero_ff <= res_zero;
      pc_ff   <= nxt_pc;
      void_ff <= nxt_void;
    end
  end

  // Software registers, which hold until rewritten, and read data, which stands for one clock only.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_ff   <= 1'b0;
      plh_ff   <= PLH_RST;
      rdata_ff <= '0;
    end
    else
    begin
      if (wr_ctrl)
        run_ff <= reg_wdata[CTRL_RUN_BIT];
      if (wr_plh)
        plh_ff <= reg_wdata[PLH_W-1:0];
      rdata_ff <= nxt_rdata;
    end
  end

  // Every output is a flip-flop.
  assign reg_rdata  = rdata_ff;
  assign prog_addr  = pc_ff;
  assign file_addr  = file_addr_ff;
  assign file_wdata = file_wdata_ff;
  assign file_we    = file_we_ff;
  assign phase      = phase_ff;

endmodule : core_subset

// File: sim/mem_model.sv
// Program and file memory facing the core subset.
// Assumes the bench preloads both arrays while the core is idle.
`timescale 1ns/1ps
module mem_model
  import core_subset_pkg::*;
(
  input  wire logic               clock,
  input  wire logic [PC_W-1:0]    prog_addr,
  output logic      [INSN_W-1:0]  prog_data,
  input  wire logic [FADDR_W-1:0] file_addr,
  output logic      [DATA_W-1:0]  file_rdata,
  input  wire logic [DATA_W-1:0]  file_wdata,
  input  wire logic               file_we
);
  logic [INSN_W-1:0] prog [8192];
  logic [DATA_W-1:0] fm   [128];
  // Both reads answer at once, as on-chip memory does.
  assign prog_data  = prog[prog_addr];
  assign file_rdata = fm[file_addr];
  // Plain always, so the bench may also preload this array.
  always @(posedge clock)
    if (file_we)
      fm[file_addr] <= file_wdata;
endmodule : mem_model

// File: sim/core_subset_monitor.sv
// Checker on the core subset ports, bound to each instance.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module core_subset_monitor
  import core_subset_pkg::*;
(
  input wire logic               clock,
  input wire logic               rst_n,
  input wire logic               reg_rd,
  input wire logic [RDATA_W-1:0] reg_rdata,
  input wire logic [PC_W-1:0]    prog_addr,
  input wire logic [INSN_W-1:0]  prog_data,
  input wire logic [FADDR_W-1:0] file_addr,
  input wire logic               file_we,
  input wire logic [1:0]         phase
);
  // Nothing is judged in reset; jump marks a fetched branch word.
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire jump = prog_data[13:11] == OP_BRANCH;
  // File field of the fetched word, named so that $past sees a signal.
  wire [FADDR_W-1:0] fa_word = prog_data[FADDR_W-1:0];
  property p_step; phase != 2'h0 |=> phase == 2'($past(phase) + 2'h1);
  endproperty
  a_step: assert property (p_step) else $error("phase");
  property p_we; file_we |-> phase == 2'h3; endproperty
  a_we: assert property (p_we) else $error("we phase");
  property p_pulse; file_we |=> !file_we; endproperty
  a_pulse: assert property (p_pulse) else $error("we long");
  property p_pc_hold; phase != 2'h3 |=> $stable(prog_addr); endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc");
  property p_pc_inc;
    phase == 2'h3 && !jump |=> prog_addr == $past(prog_addr) + 13'h1;
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("pc step");
  property p_fa_hold; phase != 2'h0 |=> $stable(file_addr); endproperty
  a_fa_hold: assert property (p_fa_hold) else $error("fa");
  property p_fa_load;
    phase == 2'h0 ##1 phase == 2'h1 |-> file_addr == $past(fa_word);
  endproperty
  a_fa_load: assert property (p_fa_load) else $error("fa load");
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata");
  // Main scenarios: a file write, a branch and a read answer.
  c_we: cover property (file_we);
  c_jump: cover property (phase == 2'h3 && jump);
  c_rd: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule : core_subset_monitor

bind core_subset core_subset_monitor i_mon (.clock(clock), .rst_n(rst_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_addr(prog_addr),
  .prog_data(prog_data), .file_addr(file_addr), .file_we(file_we),
  .phase(phase));

// File: sim/test_byte_literal_instruction_subset.sv
// Bench for the core subset: register port, program runs, file results.
// Assumes the memory model's arrays may be filled from here.
`timescale 1ns/1ps
module test_byte_literal_instruction_subset
  import core_subset_pkg::*;
  ;
  logic               clock = '0, rst_n = '0, reg_wr = '0, reg_rd = '0;
  logic               file_we;
  logic [1:0]         phase;
  logic [RADDR_W-1:0] reg_addr = '0;
  logic [RDATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic [PC_W-1:0]    prog_addr;
  logic [INSN_W-1:0]  prog_data;
  logic [FADDR_W-1:0] file_addr;
  logic [DATA_W-1:0]  file_rdata, file_wdata;
  int                 errors = 0, checks_done = 0, cycles = 0;
  int                 w, z, plh, t, k, fe[4];
  // The core under test and its memory partner.
  core_subset i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .prog_addr(prog_addr), .prog_data(prog_data),
    .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wdata(file_wdata), .file_we(file_we), .phase(phase));
  mem_model i_mem (.clock(clock), .prog_addr(prog_addr),
    .prog_data(prog_data), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wdata(file_wdata), .file_we(file_we));
  // 50 MHz clock, and a cycle ceiling far past the planned run.
  always #10 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      errors++;
      end_of_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : check
  // One bus cycle; a read compares the masked answer a cycle later.
  task automatic bus(input logic we, input logic [7:0] a, input int d,
                     input int m = -1);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= we;
    reg_rd <= !we;
    @(posedge clock);
    reg_wr <= '0;
    reg_rd <= '0;
    @(negedge clock);
    if (!we) check(reg_rdata & m, d);
  endtask : bus
  task automatic pw(input int a, input int v);
    i_mem.prog[a] = 14'(v);
  endtask : pw
  // Result routing of the bench model: destination bit, then zero flag.
  task automatic res(input int d, input int f, input int r, input int zf);
    if (d) fe[f] = r;
    else w = r;
    if (zf) z = r == 0;
  endtask : res
  // Random program from reset: run, stop, then compare with the model.
  task automatic round(input int n);
    int r, l, s, d[4];
    @(posedge clock);
    rst_n <= '0;
    @(posedge clock);
    rst_n <= '1;
    r = $urandom_range(255);
    l = $urandom_range(255);
    plh = $urandom_range(31);
    // Targets sit one past a multiple of four, so the voided landing word
    // and both loop words read back as the same masked counter.
    k = $urandom_range('h1FF, 4) * 4 + 1;
    t = (plh & 'h18) << 8 | k;
    foreach (d[i]) d[i] = $urandom_range(1);
    foreach (fe[i]) fe[i] = $urandom_range(1) ? 'hFF : $urandom_range(255);
    foreach (fe[i]) i_mem.fm[124 + i] = 8'(fe[i]);
    pw(0, 'h3000 | $urandom_range(3) << 8 | r);
    pw(1, 'h00FC);
    pw(2, 'h3800 | l);
    pw(3, 'h047D | d[0] << 7);
    pw(4, 'h0A7E | d[1] << 7);
    pw(5, 'h087F | d[2] << 7);
    pw(6, 'h0F7E | d[3] << 7);
    pw(7, 'h305A);
    pw(8, 'h2800 | k);
    // The landing word is voided; a no-op keeps it defined. The target
    // stores the working register over the first cell, proving it runs.
    pw(t - 1, 'h0000);
    pw(t, 'h00FC);
    pw(t + 1, 'h2800 | k);
    bus(1, REG_PCHIGH, 'hFFFF_FFE0 | plh);
    bus(0, REG_PCHIGH, plh);
    bus(1, REG_CTRL, 1);
    repeat (160) @(posedge clock);
    bus(1, REG_CTRL, 0);
    w = r | l;
    fe[0] = r;
    res(d[0], 1, w | fe[1], 1);
    res(d[1], 2, (fe[2] + 1) & 255, 1);
    res(d[2], 3, fe[3], 1);
    s = fe[2] == 255;
    res(d[3], 2, (fe[2] + 1) & 255, 0);
    if (!s) w = 'h5A;
    fe[0] = w;
    bus(0, REG_WORK, w);
    bus(0, REG_STATUS, z, 1);
    bus(0, REG_PC, t & 'h1FFC, 'h1FFC);
    foreach (fe[i]) check(i_mem.fm[124 + i], fe[i]);
    $display("round %0d done", n);
  endtask : round
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // Reset, register map spot checks, then four random programs.
  initial
  begin
    void'($urandom(80));
    repeat (20) @(posedge clock);
    rst_n <= '1;
    bus(0, REG_CTRL, 0);
    bus(1, REG_WORK, 'h77);
    bus(0, REG_WORK, WORK_RST);
    bus(0, 'h20, 0);
    $display("registers done");
    for (int n = 0; n < 4; n++) round(n);
    end_of_test();
  end
endmodule : test_byte_literal_instruction_subset
